/* File: hdl/lmc_defines.svh */
/*
  Constants of the line interface configuration port: command register
  offsets, field positions, serial frame layout, reset values and the
  receive loss-of-signal zero counts.
  Assumes it is included by its bare name wherever the constants are used.
*/
// Function
// - Loss declared after 10 to 255 zeros
// - Extended option waits up to 4096 zeros
// - Mode high selects strap-pin configuration
// - Shared pins become loopback and channel straps
// - Driver power-down pins act in both modes
// - Low loopback enable activates loopback
// - Type high analog, low remote loopback
// - No digital local loopback with straps
// - Channel straps pick one or all seven
// - Rail strap high single, low/open dual
// - Receive update edge from polarity strap
// - Host mode: receive edge from global bit 1
// - Transmit sample edge from polarity strap
// - Host mode: transmit edge from global bit 0
// - All-ones pin sends ones on master clock, in strap mode only
// - Mode low or open enables host port
// - Host writes registers, device applies them
// - Four wires: select, clock, data in, out
// - Each access: selection then data phase
// - Eight selection bits taken on rising edges
// - First bit: 1 read, 0 write
// - Bits two to five: address, LSB first
// - Eight data clocks; reads shift out LSB first
// - Writes take seven bits, load at end
`ifndef LMC_DEFINES_SVH
`define LMC_DEFINES_SVH

// ==========================================================================
// Command register offsets
`define LMC_REG_GLOBAL     4'h0
`define LMC_REG_LOCAL_LB   4'h1
`define LMC_REG_REMOTE_LB  4'h2
`define LMC_REG_ANALOG_LB  4'h3
`define LMC_REG_TX_ONES    4'h4
`define LMC_REG_RX_ONES    4'h5
`define LMC_REG_PWRDN      4'h6
`define LMC_REG_LAST       4'h6
`define LMC_REG_RESET      7'h00

// ==========================================================================
// Global register fields
`define LMC_GBL_TX_POL     0
`define LMC_GBL_RX_POL     1
`define LMC_GBL_CODE       2
`define LMC_GBL_RAIL       3
`define LMC_GBL_MUTE       4
`define LMC_GBL_EXT_LOSS   5
`define LMC_GBL_AUTO_ONES  6

// ==========================================================================
// Serial frame layout, counted in rising clock edges from zero
`define LMC_BIT_DIR        5'h00
`define LMC_BIT_ADDR_FIRST 5'h01
`define LMC_BIT_ADDR_LAST  5'h04
`define LMC_BIT_DATA_FIRST 5'h08
`define LMC_BIT_DATA_LAST  5'h0F
`define LMC_FRAME_BITS     5'h10

// ==========================================================================
// Loss-of-signal zero counts
`define LMC_LOSS_MIN       10
`define LMC_LOSS_MAX       255
`define LMC_LOSS_DEF       255
`define LMC_EXT_LOSS_DEF   4096

`endif

/* File: hdl/lmc_pkg.sv */
/*
  Types of the line interface configuration port.
  Assumes seven channels and seven-bit command registers.
*/
package lmc_pkg;

  typedef logic [6:0]      lmc_chan_t;
  typedef logic [6:0][6:0] lmc_bank_t;

  // ==========================================================================
  // Strap and control pins as sampled
  typedef struct packed {
    logic       mode_hw;
    logic       loopback_enable_n;
    logic       loopback_type_sel;
    logic [2:0] loop_chan_sel;
    logic       rail_format_sel;
    logic       rx_edge_polarity;
    logic       tx_edge_polarity;
    lmc_chan_t  chan_all_ones_tx;
    lmc_chan_t  chan_driver_powerdown;
  } lmc_pins_t;

  // ==========================================================================
  // Effective configuration handed to the line channels
  typedef struct packed {
    logic      host_mode;
    logic      single_rail;
    logic      hdb3_code;
    logic      rx_update_rise;
    logic      tx_sample_rise;
    logic      rx_mute;
    logic      rx_auto_all_ones;
    lmc_chan_t local_loop;
    lmc_chan_t remote_loop;
    lmc_chan_t analog_loop;
    lmc_chan_t tx_all_ones;
    lmc_chan_t rx_all_ones;
    lmc_chan_t driver_powerdown;
  } lmc_cfg_t;

  // ==========================================================================
  // System clock domain state
  typedef struct packed {
    lmc_pins_t        pin_meta;
    lmc_pins_t        pin_sync;
    logic             wr_meta;
    logic             wr_s1;
    logic             wr_s2;
    lmc_bank_t        regs;
    logic [6:0][12:0] zero_cnt;
    lmc_chan_t        lost;
    lmc_cfg_t         cfg;
  } lmc_sys_t;

  // ==========================================================================
  // Serial clock domain state: per frame, cleared by deselect
  typedef struct packed {
    logic [4:0] cnt;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wsh;
  } lmc_frame_t;

  // Serial clock domain state: held across frames
  typedef struct packed {
    lmc_bank_t  rb_meta;
    lmc_bank_t  rb_sync;
    logic [3:0] wr_addr;
    logic [6:0] wr_data;
    logic       wr_tog;
  } lmc_keep_t;

  typedef struct packed {
    logic oe;
    logic bit_out;
  } lmc_sdo_t;

endpackage

/* File: hdl/lmc_cfg_port.sv */
/*
  Mode selection, strap decode, command registers, serial host port and
  receive loss-of-signal detection of a seven-channel line interface.
  Assumes straps and rx bit strobes: straps are asynchronous, the rx bit
  strobes come from logic on clk_i. The host serial clock is a clock of its
  own that stands still outside frames.
*/
`include "lmc_defines.svh"

module lmc_cfg_port
  import lmc_pkg::*;
#(
  parameter int LOSS_ZEROS     = `LMC_LOSS_DEF,
  parameter int EXT_LOSS_ZEROS = `LMC_EXT_LOSS_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       mode_hw_i,
  input  wire logic       loopback_enable_n_i,
  input  wire logic       loopback_type_sel_i,
  input  wire logic [2:0] loop_chan_sel_i,
  input  wire logic       rail_format_sel_i,
  input  wire logic       rx_edge_polarity_i,
  input  wire logic       tx_edge_polarity_i,
  input  wire lmc_chan_t  chan_all_ones_tx_i,
  input  wire lmc_chan_t  chan_driver_powerdown_i,
  input  wire lmc_chan_t  rx_bit_stb_i,
  input  wire lmc_chan_t  rx_mark_i,
  input  wire logic       host_cs_n_i,
  input  wire logic       host_sclk_i,
  input  wire logic       host_sdi_i,
  output logic            host_sdo_o,
  output logic            host_sdo_oe_o,
  output lmc_cfg_t        cfg_o,
  output lmc_chan_t       rx_signal_lost_o
);

  // ==========================================================================
  // Elaboration checks
  if (LOSS_ZEROS < `LMC_LOSS_MIN || LOSS_ZEROS > `LMC_LOSS_MAX) begin : g_chk_loss
    $error("LOSS_ZEROS outside the allowed zero-run range");
  end
  if (EXT_LOSS_ZEROS <= LOSS_ZEROS || EXT_LOSS_ZEROS > 8191) begin : g_chk_ext
    $error("EXT_LOSS_ZEROS must exceed LOSS_ZEROS and fit 13 bits");
  end
  if (`LMC_BIT_DATA_LAST - `LMC_BIT_DATA_FIRST != 7) begin : g_chk_data
    $error("Data phase must span eight serial clocks");
  end
  if (`LMC_BIT_ADDR_LAST - `LMC_BIT_ADDR_FIRST != 3) begin : g_chk_addr
    $error("Address field must hold four bits");
  end
  if (`LMC_FRAME_BITS != `LMC_BIT_DATA_LAST + 1) begin : g_chk_frame
    $error("Frame length must follow the last data bit");
  end
  if (`LMC_REG_LAST > 4'h6) begin : g_chk_regs
    $error("Register bank holds seven registers");
  end

  localparam logic [12:0] LOSS_LIM = 13'(LOSS_ZEROS);
  localparam logic [12:0] EXT_LIM  = 13'(EXT_LOSS_ZEROS);

  // ==========================================================================
  // Decoding functions
  // Channel strap code: 0..6 one channel, 7 all channels
  function automatic lmc_chan_t chan_decode(input logic [2:0] sel);
    lmc_chan_t r;
    r = '0;
    if (sel == 3'h7) begin
      r = 7'h7F;
    end else begin
      r[sel] = 1'b1;
    end
    return r;
  endfunction

  // Register file read; unmapped addresses read zero
  function automatic logic reg_bit(input lmc_bank_t bank, input logic [3:0] addr,
                                   input logic [2:0] idx);
    logic r;
    r = 1'b0;
    if (addr <= `LMC_REG_LAST && idx != 3'h7) begin
      r = bank[addr[2:0]][idx];
    end
    return r;
  endfunction

  // Serial edge count decode
  function automatic logic in_addr_phase(input logic [4:0] cnt);
    return cnt >= `LMC_BIT_ADDR_FIRST && cnt <= `LMC_BIT_ADDR_LAST;
  endfunction

  function automatic logic in_data_phase(input logic [4:0] cnt);
    return cnt >= `LMC_BIT_DATA_FIRST && cnt <= `LMC_BIT_DATA_LAST;
  endfunction

  // One received bit: a mark clears the run, zeros count up to the limit
  function automatic logic [13:0] loss_step(input logic [12:0] cnt,
                                            input logic        lost,
                                            input logic        mark,
                                            input logic [12:0] lim);
    logic [12:0] c;
    logic        l;
    c = cnt;
    l = lost;
    if (mark) begin
      c = '0;
      l = 1'b0;
    end else if (cnt < lim) begin
      c = cnt + 13'h0001;
      if (c >= lim) begin
        l = 1'b1;
      end
    end else begin
      l = 1'b1;
    end
    return {l, c};
  endfunction

  lmc_sys_t   sys_q;
  lmc_sys_t   sys_d;
  lmc_frame_t frm_q;
  lmc_frame_t frm_d;
  lmc_keep_t  keep_q;
  lmc_keep_t  keep_d;
  lmc_sdo_t   sdo_q;
  lmc_sdo_t   sdo_d;
  lmc_pins_t  pins_now;

  assign pins_now = '{
    mode_hw:               mode_hw_i,
    loopback_enable_n:     loopback_enable_n_i,
    loopback_type_sel:     loopback_type_sel_i,
    loop_chan_sel:         loop_chan_sel_i,
    rail_format_sel:       rail_format_sel_i,
    rx_edge_polarity:      rx_edge_polarity_i,
    tx_edge_polarity:      tx_edge_polarity_i,
    chan_all_ones_tx:      chan_all_ones_tx_i,
    chan_driver_powerdown: chan_driver_powerdown_i
  };

  // ==========================================================================
  // Loss-of-signal step of each channel
  wire logic [6:0][13:0] loss_nxt;
  logic      [12:0]      loss_lim;

  assign loss_lim = (!sys_q.pin_sync.mode_hw && sys_q.regs[`LMC_REG_GLOBAL][`LMC_GBL_EXT_LOSS]) ?
                    EXT_LIM : LOSS_LIM;

  for (genvar ch = 0; ch < 7; ch++) begin : g_loss
    assign loss_nxt[ch] = rx_bit_stb_i[ch] ?
                          loss_step(sys_q.zero_cnt[ch], sys_q.lost[ch], rx_mark_i[ch], loss_lim) :
                          {sys_q.lost[ch], sys_q.zero_cnt[ch]};
  end

  // ==========================================================================
  // System clock domain: straps, registers, loss detection
  always_comb begin
    lmc_pins_t  p;
    lmc_bank_t  r;
    lmc_chan_t  sel;
    logic       host;
    logic       wr_evt;
    p      = sys_q.pin_sync;
    r      = sys_q.regs;
    sel    = chan_decode(p.loop_chan_sel);
    host   = ~p.mode_hw;
    wr_evt = sys_q.wr_s1 ^ sys_q.wr_s2;
    sys_d  = sys_q;

    sys_d.pin_meta = pins_now;
    sys_d.pin_sync = sys_q.pin_meta;
    sys_d.wr_meta  = keep_q.wr_tog;
    sys_d.wr_s1    = sys_q.wr_meta;
    sys_d.wr_s2    = sys_q.wr_s1;

    // Write data is held in the serial domain until the next write frame
    if (host && wr_evt && keep_q.wr_addr <= `LMC_REG_LAST) begin
      sys_d.regs[keep_q.wr_addr[2:0]] = keep_q.wr_data;
    end

    for (int ch = 0; ch < 7; ch++) begin
      {sys_d.lost[ch], sys_d.zero_cnt[ch]} = loss_nxt[ch];
    end

    sys_d.cfg.host_mode        = host;
    sys_d.cfg.driver_powerdown = p.chan_driver_powerdown;
    if (host) begin
      sys_d.cfg.driver_powerdown = p.chan_driver_powerdown | r[`LMC_REG_PWRDN];
      sys_d.cfg.single_rail      = r[`LMC_REG_GLOBAL][`LMC_GBL_RAIL];
      sys_d.cfg.hdb3_code        = r[`LMC_REG_GLOBAL][`LMC_GBL_CODE];
      sys_d.cfg.rx_update_rise   = r[`LMC_REG_GLOBAL][`LMC_GBL_RX_POL];
      sys_d.cfg.tx_sample_rise   = r[`LMC_REG_GLOBAL][`LMC_GBL_TX_POL];
      sys_d.cfg.rx_mute          = r[`LMC_REG_GLOBAL][`LMC_GBL_MUTE];
      sys_d.cfg.rx_auto_all_ones = r[`LMC_REG_GLOBAL][`LMC_GBL_AUTO_ONES];
      sys_d.cfg.local_loop       = r[`LMC_REG_LOCAL_LB];
      sys_d.cfg.remote_loop      = r[`LMC_REG_REMOTE_LB];
      sys_d.cfg.analog_loop      = r[`LMC_REG_ANALOG_LB];
      sys_d.cfg.tx_all_ones      = r[`LMC_REG_TX_ONES];
      sys_d.cfg.rx_all_ones      = r[`LMC_REG_RX_ONES];
    end else begin
      sys_d.cfg.single_rail      = p.rail_format_sel;
      sys_d.cfg.hdb3_code        = 1'b0;
      sys_d.cfg.rx_update_rise   = p.rx_edge_polarity;
      sys_d.cfg.tx_sample_rise   = p.tx_edge_polarity;
      sys_d.cfg.rx_mute          = 1'b0;
      sys_d.cfg.rx_auto_all_ones = 1'b0;
      sys_d.cfg.local_loop       = '0;
      sys_d.cfg.remote_loop      = '0;
      sys_d.cfg.analog_loop      = '0;
      if (!p.loopback_enable_n) begin
        if (p.loopback_type_sel) begin
          sys_d.cfg.analog_loop = sel;
        end else begin
          sys_d.cfg.remote_loop = sel;
        end
      end
      sys_d.cfg.tx_all_ones      = p.chan_all_ones_tx;
      sys_d.cfg.rx_all_ones      = '0;
    end

    if (reset_i) begin
      sys_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    sys_q <= sys_d;
  end

  assign cfg_o            = sys_q.cfg;
  assign rx_signal_lost_o = sys_q.lost;

  // ==========================================================================
  // Serial clock domain: selection and data phases
  always_comb begin
    frm_d = frm_q;
    keep_d = keep_q;
    keep_d.rb_meta = sys_q.regs;
    keep_d.rb_sync = keep_q.rb_meta;

    // Counter saturates so stray edges after a frame do nothing
    if (frm_q.cnt != `LMC_FRAME_BITS) begin
      frm_d.cnt = frm_q.cnt + 5'h01;
    end
    if (frm_q.cnt == `LMC_BIT_DIR) begin
      frm_d.rd = host_sdi_i;
    end
    if (in_addr_phase(frm_q.cnt)) begin
      frm_d.addr = {host_sdi_i, frm_q.addr[3:1]};
    end
    if (in_data_phase(frm_q.cnt)) begin
      frm_d.wsh = {host_sdi_i, frm_q.wsh[7:1]};
    end
    if (frm_q.cnt == `LMC_BIT_DATA_LAST && !frm_q.rd) begin
      keep_d.wr_addr = frm_q.addr;
      keep_d.wr_data = frm_d.wsh[6:0];
      keep_d.wr_tog  = ~keep_q.wr_tog;
    end
  end

  // Deselect clears the frame, so each assertion starts at bit zero
  always_ff @(posedge host_sclk_i or posedge host_cs_n_i) begin
    if (host_cs_n_i) begin
      frm_q <= '0;
    end else begin
      frm_q <= frm_d;
    end
  end

  // The serial clock stands still during reset, so reset acts without it
  always_ff @(posedge host_sclk_i or posedge reset_i) begin
    if (reset_i) begin
      keep_q <= '0;
    end else begin
      keep_q <= keep_d;
    end
  end

  // ==========================================================================
  // Read data leaves on falling edges, lowest bit first
  always_comb begin
    sdo_d = '0;
    if (frm_q.rd && in_data_phase(frm_q.cnt)) begin
      sdo_d.oe      = 1'b1;
      sdo_d.bit_out = reg_bit(keep_q.rb_sync, frm_q.addr, frm_q.cnt[2:0]);
    end
  end

  always_ff @(negedge host_sclk_i or posedge host_cs_n_i) begin
    if (host_cs_n_i) begin
      sdo_q <= '0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  assign host_sdo_o    = sdo_q.bit_out;
  assign host_sdo_oe_o = sdo_q.oe & sys_q.cfg.host_mode;

endmodule

/* File: verification/lmc_cfg_port_checker.sv */
/*
  Concurrent checks on the ports of lmc_cfg_port.
  Assumes it is bound to lmc_cfg_port and that the straps settle between changes.
*/
module lmc_cfg_port_checker
  import lmc_pkg::*;
(
  input wire logic      clk_i,
  input wire logic      reset_i,
  input wire logic      mode_hw_i,
  input wire logic      loopback_enable_n_i,
  input wire logic      loopback_type_sel_i,
  input wire logic      rail_format_sel_i,
  input wire lmc_chan_t chan_driver_powerdown_i,
  input wire lmc_chan_t rx_bit_stb_i,
  input wire lmc_chan_t rx_mark_i,
  input wire logic      host_cs_n_i,
  input wire logic      host_sdo_oe_o,
  input wire lmc_cfg_t  cfg_o,
  input wire lmc_chan_t rx_signal_lost_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_oe_deselected: assert property (host_cs_n_i |-> !host_sdo_oe_o)
    else $error("sdo enabled while deselected");
  a_oe_strap_mode: assert property (mode_hw_i [*5] |-> !host_sdo_oe_o)
    else $error("sdo enabled in strap mode");
  a_host_mode_flag: assert property ($stable(mode_hw_i) [*5] |-> cfg_o.host_mode == !mode_hw_i)
    else $error("host mode flag does not follow mode pin");
  a_lost_cause: assert property ((rx_signal_lost_o & ~$past(rx_signal_lost_o)
    & ~$past(rx_bit_stb_i & ~rx_mark_i)) == 7'h00)
    else $error("loss raised without a zero strobe");
  a_mark_clears: assert property (|(rx_bit_stb_i & rx_mark_i) |=>
    (rx_signal_lost_o & $past(rx_bit_stb_i & rx_mark_i)) == 7'h00)
    else $error("loss kept after a mark");
  a_no_local_loop: assert property (!cfg_o.host_mode |->
    cfg_o.local_loop == 7'h00 && !cfg_o.hdb3_code && cfg_o.rx_all_ones == 7'h00)
    else $error("host-only setting active in strap mode");
  a_loop_disabled: assert property ((mode_hw_i && loopback_enable_n_i) [*5] |->
    (cfg_o.remote_loop | cfg_o.analog_loop) == 7'h00)
    else $error("loopback without enable");
  a_remote_only: assert property ((mode_hw_i && !loopback_type_sel_i) [*5] |->
    cfg_o.analog_loop == 7'h00)
    else $error("analog loop with type low");
  a_analog_only: assert property ((mode_hw_i && loopback_type_sel_i) [*5] |->
    cfg_o.remote_loop == 7'h00)
    else $error("remote loop with type high");
  a_pd_pins: assert property ($stable(chan_driver_powerdown_i) [*5] |->
    (cfg_o.driver_powerdown & chan_driver_powerdown_i) == chan_driver_powerdown_i)
    else $error("power-down pin not applied");
  a_rail_strap: assert property ((mode_hw_i && $stable(rail_format_sel_i)) [*5] |->
    cfg_o.single_rail == rail_format_sel_i)
    else $error("rail format does not follow strap");

  c_lost: cover property ($rose(|rx_signal_lost_o));
  c_read: cover property ($rose(host_sdo_oe_o));
  c_remote: cover property (cfg_o.remote_loop != 7'h00);
endmodule

/* File: verification/lmc_host_model.sv */
/*
  Behavioural host driving the four-wire serial port.
  Assumes the serial clock runs only inside frames, 125 ns period.
*/
module lmc_host_model (
  output logic       host_cs_n_o,
  output logic       host_sclk_o,
  output logic       host_sdi_o,
  input  wire logic  host_sdo_i,
  input  wire logic  host_sdo_oe_i,
  output logic       rd_stb_o,
  output logic [7:0] rd_val_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    host_cs_n_o = 1'b0;
    host_sclk_o = 1'b0;
    host_sdi_o = 1'b0;
    rd_stb_o = 1'b0;
    rd_val_o = 8'h00;
    // A clean deselect edge clears the frame logic before the first frame
    #20 host_cs_n_o = 1'b1;
  end

  // Sends n clocks of one frame; fewer than 16 aborts it
  task automatic frame(input logic rd, input logic [3:0] a, input logic [7:0] d, input int n);
    logic [15:0] f;
    f = {d, 3'b000, a, rd};
    host_cs_n_o = 1'b0;
    #60;
    for (int k = 0; k < n; k++) begin
      host_sdi_o = f[k];
      #62.5 host_sclk_o = 1'b1;
      if (k > 7)
        rd_val_o = {host_sdo_oe_i ? host_sdo_i : 1'bx, rd_val_o[7:1]};
      #62.5 host_sclk_o = 1'b0;
    end
    #60 host_cs_n_o = 1'b1;
    host_sdi_o = ~host_sdi_o;
    if (rd && n == 16) begin
      rd_stb_o = 1'b1;
      #1 rd_stb_o = 1'b0;
    end
    #300;
  endtask
endmodule

/* File: verification/lmc_cfg_port_bench.sv */
/*
  Self-checking bench of lmc_cfg_port: straps, serial access, loss detect.
  Assumes the host model of lmc_host_model and short loss counts.
*/
module lmc_cfg_port_bench
  import lmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk_i;
  logic       reset_i;
  lmc_pins_t  p;
  lmc_chan_t  stb;
  lmc_chan_t  mark;
  lmc_chan_t  lost;
  lmc_cfg_t   cfg;
  logic       cs_n;
  logic       sclk;
  logic       sdi;
  logic       sdo;
  logic       sdo_oe;
  logic       rd_stb;
  logic [7:0] rd_val;
  logic [6:0] r [7];
  logic [7:0] exp_q [$];
  int         n_mismatch;
  int         n_checks;

  lmc_cfg_port #(.LOSS_ZEROS(10), .EXT_LOSS_ZEROS(20)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .mode_hw_i(p.mode_hw),
    .loopback_enable_n_i(p.loopback_enable_n), .loopback_type_sel_i(p.loopback_type_sel),
    .loop_chan_sel_i(p.loop_chan_sel), .rail_format_sel_i(p.rail_format_sel),
    .rx_edge_polarity_i(p.rx_edge_polarity), .tx_edge_polarity_i(p.tx_edge_polarity),
    .chan_all_ones_tx_i(p.chan_all_ones_tx), .chan_driver_powerdown_i(p.chan_driver_powerdown),
    .rx_bit_stb_i(stb), .rx_mark_i(mark), .host_cs_n_i(cs_n), .host_sclk_i(sclk),
    .host_sdi_i(sdi), .host_sdo_o(sdo), .host_sdo_oe_o(sdo_oe), .cfg_o(cfg),
    .rx_signal_lost_o(lost));

  lmc_host_model host (.host_cs_n_o(cs_n), .host_sclk_o(sclk), .host_sdi_o(sdi),
    .host_sdo_i(sdo), .host_sdo_oe_i(sdo_oe), .rd_stb_o(rd_stb), .rd_val_o(rd_val));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic lmc_cfg_t hw_cfg(lmc_pins_t v);
    lmc_chan_t s;
    s = (v.loop_chan_sel == 3'h7) ? 7'h7F : 7'(8'h01 << v.loop_chan_sel);
    if (v.loopback_enable_n)
      s = 7'h00;
    return '{1'b0, v.rail_format_sel, 1'b0, v.rx_edge_polarity, v.tx_edge_polarity, 1'b0,
             1'b0, 7'h00, v.loopback_type_sel ? 7'h00 : s, v.loopback_type_sel ? s : 7'h00,
             v.chan_all_ones_tx, 7'h00, v.chan_driver_powerdown};
  endfunction

  function automatic lmc_cfg_t host_cfg(lmc_chan_t pd);
    return '{1'b1, r[0][3], r[0][2], r[0][1], r[0][0], r[0][4], r[0][6],
             r[1], r[2], r[3], r[4], r[5], pd | r[6]};
  endfunction

  task automatic rd(input logic [3:0] a);
    exp_q.push_back(a < 4'h7 ? {1'b0, r[a[2:0]]} : 8'h00);
    host.frame(1'b1, a, 8'($urandom), 16);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input int n);
    if (a < 4'h7 && n == 16 && !p.mode_hw)
      r[a[2:0]] = d[6:0];
    host.frame(1'b0, a, d, n);
    repeat (8) @(posedge clk_i);
  endtask

  task automatic pulse(input int ch, input logic m, input int cnt, input logic exp);
    for (int k = 0; k < cnt; k++) begin
      @(posedge clk_i);
      stb <= 7'(8'h01 << ch);
      mark <= {7{m}};
      @(posedge clk_i);
      stb <= 7'h00;
    end
    repeat (2) @(posedge clk_i);
    chk("loss flag", 64'(lost[ch]), 64'(exp));
  endtask

  always @(posedge rd_stb)
    chk("read data", 64'(rd_val), 64'(exp_q.pop_front()));

  initial begin
    #2ms;
    n_mismatch++;
    test_done();
  end

  initial begin
    lmc_pins_t v;
    int        ch;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'h11b7));
    reset_i = 1'b0;
    // A real rising edge so the serial-side hold registers see reset
    #10 reset_i = 1'b1;
    p = '0;
    stb = 7'h00;
    mark = 7'h00;
    r = '{default: 7'h00};
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      v = lmc_pins_t'($urandom);
      v.mode_hw = 1'b1;
      v.loopback_enable_n = (i > 13);
      {v.loopback_type_sel, v.loop_chan_sel} = 4'(i);
      @(posedge clk_i);
      p <= v;
      repeat (5) @(posedge clk_i);
      chk("strap cfg", cfg, hw_cfg(v));
    end
    wr(4'h1, 8'h7F, 16);
    v = '0;
    v.chan_driver_powerdown = 7'($urandom);
    @(posedge clk_i);
    p <= v;
    repeat (5) @(posedge clk_i);
    for (int a = 0; a < 16; a++)
      rd(4'(a));
    for (int a = 0; a < 16; a++)
      wr(4'(a), 8'($urandom), 16);
    for (int a = 0; a < 16; a++)
      rd(4'(a));
    chk("host cfg", cfg, host_cfg(v.chan_driver_powerdown));
    wr(4'h2, 8'(~r[2]), 10);
    rd(4'h2);
    for (int j = 0; j < 2; j++) begin
      wr(4'h0, {2'($urandom), j[0], 5'($urandom)}, 16);
      ch = $urandom_range(6);
      pulse(ch, 1'b1, 1, 1'b0);
      pulse(ch, 1'b0, (j == 1 ? 20 : 10) - 1, 1'b0);
      pulse(ch, 1'b0, 1, 1'b1);
      pulse(ch, 1'b1, 1, 1'b0);
    end
    test_done();
  end
endmodule

bind lmc_cfg_port lmc_cfg_port_checker checker_i (.clk_i, .reset_i, .mode_hw_i,
  .loopback_enable_n_i, .loopback_type_sel_i, .rail_format_sel_i, .chan_driver_powerdown_i,
  .rx_bit_stb_i, .rx_mark_i, .host_cs_n_i, .host_sdo_oe_o, .cfg_o, .rx_signal_lost_o);
